//--- shared/ell_defines.svh
// register offsets, field positions, reset values and codes of the link loss policy block
// assumes a 32-bit apb slave decoding pAddr[11:0]
`ifndef ELL_DEFINES_SVH
`define ELL_DEFINES_SVH

// ==========================================================
// register offsets
`define ELL_ADDR_PORT1_ACT  12'h000
`define ELL_ADDR_PORT2_ACT  12'h004
`define ELL_ADDR_STOP_MODE  12'h008
`define ELL_ADDR_SLOT0      12'h00C
`define ELL_ADDR_SLOT1      12'h010
`define ELL_ADDR_SLOT2      12'h014
`define ELL_ADDR_SLOT3      12'h018
`define ELL_ADDR_SLOT_EFF   12'h01C
`define ELL_ADDR_LINK_STAT  12'h020
`define ELL_ADDR_INT_STAT   12'h024
`define ELL_ADDR_INT_EN     12'h028
`define ELL_ADDR_INT_CLR    12'h02C

// ==========================================================
// reset values
`define ELL_RST_PORT1_ACT   2'h3
`define ELL_RST_PORT2_ACT   16'h270F
`define ELL_RST_STOP_MODE   2'h0
`define ELL_RST_SLOT0       16'h1389
`define ELL_RST_SLOT1       16'hB0B5
`define ELL_RST_SLOT2       16'hB0B6
`define ELL_RST_SLOT3       16'h270F

// ==========================================================
// action and combining codes
`define ELL_ACT_OFF         2'h0
`define ELL_ACT_WARN        2'h1
`define ELL_ACT_ALARM       2'h2
`define ELL_ACT_FAULT       2'h3
`define ELL_P2_BOTH         16'h22B8
`define ELL_P2_EITHER       16'h270F
`define ELL_P2_MAX_OWN      16'h0003
`define ELL_STOP_ALARM      2'h0

// ==========================================================
// protocol slot codes and client limits
`define ELL_CODE_NONE       16'h270F
`define ELL_CODE_MODBUS     16'h01F6
`define ELL_CODE_5000       16'h1388
`define ELL_CODE_5001       16'h1389
`define ELL_CODE_5002       16'h138A
`define ELL_CODE_5006       16'h138E
`define ELL_CODE_5007       16'h138F
`define ELL_CODE_5008       16'h1390
`define ELL_CODE_5010       16'h1392
`define ELL_CODE_5011       16'h1393
`define ELL_CODE_5012       16'h1394
`define ELL_CODE_5013       16'h1395
`define ELL_LIM_NONE        3'h0
`define ELL_LIM_MODBUS      3'h3
`define ELL_LIM_TCP         3'h2

// ==========================================================
// interrupt bit positions
`define ELL_IRQ_WARN        0
`define ELL_IRQ_FAULT       1
`define ELL_IRQ_REFUSE      2

`endif

//--- shared/ell_pkg.sv
// types shared by the link loss policy block
// constants live in ell_defines.svh
package ell_pkg;

  typedef enum logic [1:0]
  {
    ELL_OK    = 2'b00,
    ELL_WARN  = 2'b01,
    ELL_FAULT = 2'b11
  } ell_loss_e;

  typedef logic [15:0] ell_code_t;
  typedef logic [2:0]  ell_key_t;
  typedef logic [2:0]  ell_cnt_t;

  localparam ell_key_t ELL_KEY_NONE = 3'h0;
  localparam ell_key_t ELL_KEY_OTHER = 3'h6;

  typedef struct packed
  {
    logic [3:0]           eff;
    logic [3:0][2:0]      limit;
  } ell_rank_s;

  typedef struct packed
  {
    logic [3:0][2:0]      count;
  } ell_cli_s;

endpackage : ell_pkg

//--- design/ell_slot_rank.sv
// ranks the four protocol slots and derives the client limit of each
// assumes slot codes are static register values from the owning block
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

module ell_slot_rank
  import ell_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // slot codes
  input  wire logic [3:0][15:0]  slot_code,
  // ranking
  output logic [3:0]             slot_effective,
  output logic [3:0][2:0]        slot_limit
);

  ell_rank_s st;
  ell_rank_s next_st;

  // ==========================================================
  // application and transport key
  function automatic ell_key_t ell_key(input ell_code_t c);
    case (c)
      `ELL_CODE_NONE:   ell_key = ELL_KEY_NONE;
      `ELL_CODE_MODBUS: ell_key = 3'h1;
      `ELL_CODE_5000, `ELL_CODE_5001, `ELL_CODE_5006, `ELL_CODE_5008: ell_key = 3'h2;
      `ELL_CODE_5002, `ELL_CODE_5007: ell_key = 3'h3;
      `ELL_CODE_5010, `ELL_CODE_5011: ell_key = 3'h4;
      `ELL_CODE_5012, `ELL_CODE_5013: ell_key = 3'h5;
      default:          ell_key = ELL_KEY_OTHER;
    endcase
  endfunction : ell_key

  // ==========================================================
  // ranking
  always_comb
  begin
    logic dup;
    ell_key_t ki;
    dup = 1'b0;
    ki = ELL_KEY_NONE;
    next_st = st;
    for (int i = 0; i < 4; i++)
    begin
      ki = ell_key(slot_code[i]);
      dup = 1'b0;
      // [RULE_09] earlier slot wins
      for (int j = 0; j < i; j++)
      begin
        if ((ki != ELL_KEY_OTHER && ki == ell_key(slot_code[j])) || slot_code[i] == slot_code[j])
          dup = 1'b1;
      end
      next_st.eff[i] = (ki != ELL_KEY_NONE) && !dup;
      // [RULE_10] per protocol limit
      case (ki)
        3'h1:         next_st.limit[i] = `ELL_LIM_MODBUS;
        3'h3, 3'h5:   next_st.limit[i] = `ELL_LIM_TCP;
        default:      next_st.limit[i] = `ELL_LIM_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign slot_effective = st.eff;
  assign slot_limit     = st.limit;

endmodule : ell_slot_rank
`default_nettype wire

//--- design/ell_client_limit.sv
// counts open clients per slot and refuses those beyond the limit
// assumes open and close requests are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

module ell_client_limit
  import ell_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // slot ranking
  input  wire logic [3:0]        slot_effective,
  input  wire logic [3:0][2:0]   slot_limit,
  input  wire logic              drive_reset,
  // client requests
  input  wire logic [3:0]        open_req,
  input  wire logic [3:0]        close_req,
  output logic [3:0]             open_accept,
  output logic                   open_refused,
  output logic [3:0][2:0]        client_count
);

  ell_cli_s st;
  ell_cli_s next_st;

  // ==========================================================
  // admission
  always_comb
  begin
    next_st = st;
    open_refused = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      // [RULE_10] refuse beyond limit
      open_accept[i] = open_req[i] && slot_effective[i] && !drive_reset
                       && (slot_limit[i] == `ELL_LIM_NONE || st.count[i] < slot_limit[i]);
      if (open_req[i] && !open_accept[i])
        open_refused = 1'b1;
      // unlimited slots do not count, so their counter stays at zero
      if (open_accept[i] && slot_limit[i] != `ELL_LIM_NONE && !close_req[i])
        next_st.count[i] = st.count[i] + 3'h1;
      else if (close_req[i] && !open_accept[i] && st.count[i] != 3'h0)
        next_st.count[i] = st.count[i] - 3'h1;
      // [RULE_11] reset closes tcp
      if (drive_reset || !slot_effective[i])
        next_st.count[i] = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign client_count = st.count;

endmodule : ell_client_limit
`default_nettype wire

//--- design/ell_link_loss.sv
// link loss policy with apb registers, protocol slots and client limits
// assumes link, drive state and client inputs are synchronous to pclk
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

// How it works
// [RULE_01] watch each port for signal loss
// [RULE_02] port1 action 0 off, 1 warn, 2 alarm
// [RULE_03] action 3, the default, trips fault
// [RULE_04] fault alarm follows stop mode setting
// [RULE_05] no fault while stopped or resetting
// [RULE_06] 8888 applies port1 action on both lost
// [RULE_07] 9999 applies port1 action on either lost
// [RULE_08] cyclic network trips fault on any loss
// [RULE_09] duplicate slots: lower slot number wins
// [RULE_10] client limits 3, 2 or unlimited
// [RULE_11] drive reset closes open tcp connections
// [RULE_12] integrator sets stop mode or per-port actions
// [RULE_13] port2 codes 0 to 3 act independently
// [RULE_14] warning and alarm clear when link returns
module ell_link_loss
  import ell_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // link and drive state
  input  wire logic              link_up_p1,
  input  wire logic              link_up_p2,
  input  wire logic              drive_stopped,
  input  wire logic              drive_reset,
  input  wire logic              cyclic_active,
  // clients
  input  wire logic [3:0]        open_req,
  input  wire logic [3:0]        close_req,
  output logic [3:0]             open_accept,
  // indications
  output logic                   link_loss_warning,
  output logic                   link_loss_fault,
  output logic                   alarm_output,
  output logic                   irq
);

  // ==========================================================
  // state
  typedef struct packed
  {
    logic [1:0]       port1_loss_action;
    logic [15:0]      port2_loss_action;
    logic [1:0]       comm_error_stop_mode;
    logic [3:0][15:0] protocol_slot_select;
    logic [2:0]       int_stat;
    logic [2:0]       int_en;
    ell_loss_e        loss;
    logic             alarm;
    logic [31:0]      rdata;
    logic             err;
  } ell_top_s;

  ell_top_s st;
  ell_top_s next_st;

  logic [3:0]        slot_effective;
  logic [3:0][2:0]   slot_limit;
  logic [3:0][2:0]   client_count;
  logic              open_refused;

  // ==========================================================
  // slot ranking and client admission
  ell_slot_rank u_rank
  (
    .pclk            (pclk),
    .presetn         (presetn),
    .slot_code       (st.protocol_slot_select),
    .slot_effective  (slot_effective),
    .slot_limit      (slot_limit)
  );

  ell_client_limit u_cli
  (
    .pclk            (pclk),
    .presetn         (presetn),
    .slot_effective  (slot_effective),
    .slot_limit      (slot_limit),
    .drive_reset     (drive_reset),
    .open_req        (open_req),
    .close_req       (close_req),
    .open_accept     (open_accept),
    .open_refused    (open_refused),
    .client_count    (client_count)
  );

  // ==========================================================
  // loss evaluation
  logic              loss1;
  logic              loss2;
  logic              p2_own;
  logic              hit1;
  logic              hit2;
  logic [1:0]        act2;
  logic              want_warn;
  logic              want_alarm;
  logic              want_fault;
  logic              fault_ok;

  always_comb
  begin
    // [RULE_01] loss per port
    loss1 = !link_up_p1;
    loss2 = !link_up_p2;
    p2_own = st.port2_loss_action <= `ELL_P2_MAX_OWN;
    act2 = st.port2_loss_action[1:0];
    hit1 = 1'b0;
    hit2 = 1'b0;
    if (p2_own)
    begin
      // [RULE_13] independent port actions
      hit1 = loss1;
      hit2 = loss2;
    end
    else if (st.port2_loss_action == `ELL_P2_BOTH)
      // [RULE_06] both ports lost
      hit1 = loss1 && loss2;
    else
      // [RULE_07] either port lost
      hit1 = loss1 || loss2;
    // [RULE_02] warn and alarm levels
    want_warn  = (hit1 && st.port1_loss_action != `ELL_ACT_OFF)
                 || (hit2 && act2 != `ELL_ACT_OFF);
    want_alarm = (hit1 && (st.port1_loss_action == `ELL_ACT_ALARM || st.port1_loss_action == `ELL_ACT_FAULT))
                 || (hit2 && (act2 == `ELL_ACT_ALARM || act2 == `ELL_ACT_FAULT));
    // [RULE_03] fault action
    want_fault = (hit1 && st.port1_loss_action == `ELL_ACT_FAULT)
                 || (hit2 && act2 == `ELL_ACT_FAULT);
    // [RULE_08] cyclic overrides settings
    if (cyclic_active && (loss1 || loss2))
      want_fault = 1'b1;
    // [RULE_05] suppressed while stopped
    fault_ok = !drive_stopped && !drive_reset;
  end

  // ==========================================================
  // apb decode
  logic              setup;
  logic              wr_en;
  logic              known;
  logic [31:0]       rd_mux;

  always_comb
  begin
    setup = psel && !penable;
    wr_en = psel && penable && pwrite && !st.err;
    known = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ELL_ADDR_PORT1_ACT: rd_mux = {30'h0000_0000, st.port1_loss_action};
      `ELL_ADDR_PORT2_ACT: rd_mux = {16'h0000, st.port2_loss_action};
      `ELL_ADDR_STOP_MODE: rd_mux = {30'h0000_0000, st.comm_error_stop_mode};
      `ELL_ADDR_SLOT0:     rd_mux = {16'h0000, st.protocol_slot_select[0]};
      `ELL_ADDR_SLOT1:     rd_mux = {16'h0000, st.protocol_slot_select[1]};
      `ELL_ADDR_SLOT2:     rd_mux = {16'h0000, st.protocol_slot_select[2]};
      `ELL_ADDR_SLOT3:     rd_mux = {16'h0000, st.protocol_slot_select[3]};
      `ELL_ADDR_SLOT_EFF:  rd_mux = {16'h0000, client_count, slot_effective};
      `ELL_ADDR_LINK_STAT: rd_mux = {26'h000_0000, st.loss, st.alarm, cyclic_active, loss2, loss1};
      `ELL_ADDR_INT_STAT:  rd_mux = {29'h0000_0000, st.int_stat};
      `ELL_ADDR_INT_EN:    rd_mux = {29'h0000_0000, st.int_en};
      // clear register is write only
      `ELL_ADDR_INT_CLR:   rd_mux = 32'h0000_0000;
      default:             known = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  logic [2:0]        events;
  logic [2:0]        clr;

  always_comb
  begin
    next_st = st;
    clr = 3'h0;
    // register writes take effect at the completing access edge
    if (wr_en)
    begin
      case (paddr)
        `ELL_ADDR_PORT1_ACT: next_st.port1_loss_action = pwdata[1:0];
        `ELL_ADDR_PORT2_ACT: next_st.port2_loss_action = pwdata[15:0];
        `ELL_ADDR_STOP_MODE: next_st.comm_error_stop_mode = pwdata[1:0];
        `ELL_ADDR_SLOT0:     next_st.protocol_slot_select[0] = pwdata[15:0];
        `ELL_ADDR_SLOT1:     next_st.protocol_slot_select[1] = pwdata[15:0];
        `ELL_ADDR_SLOT2:     next_st.protocol_slot_select[2] = pwdata[15:0];
        `ELL_ADDR_SLOT3:     next_st.protocol_slot_select[3] = pwdata[15:0];
        `ELL_ADDR_INT_EN:    next_st.int_en = pwdata[2:0];
        `ELL_ADDR_INT_CLR:   clr = pwdata[2:0];
        default:             clr = 3'h0;
      endcase
    end
    // read data and error captured in setup, shown in access
    if (setup)
    begin
      next_st.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      next_st.err   = !known;
    end

    // loss state machine
    case (st.loss)
      ELL_OK:
      begin
        if (want_fault && fault_ok)
          next_st.loss = ELL_FAULT;
        else if (want_warn)
          next_st.loss = ELL_WARN;
      end
      ELL_WARN:
      begin
        if (want_fault && fault_ok)
          next_st.loss = ELL_FAULT;
        // [RULE_14] clears when link returns
        else if (!want_warn)
          next_st.loss = ELL_OK;
      end
      ELL_FAULT:
      begin
        // latched until the drive is reset
        if (drive_reset)
          next_st.loss = ELL_OK;
      end
      default: next_st.loss = ELL_OK;
    endcase

    // [RULE_04] fault alarm per stop mode
    if (next_st.loss == ELL_FAULT)
      next_st.alarm = st.comm_error_stop_mode == `ELL_STOP_ALARM;
    else
      next_st.alarm = want_alarm && !want_fault && next_st.loss == ELL_WARN;

    // set wins over a clear in the same cycle
    events[`ELL_IRQ_WARN]   = next_st.loss == ELL_WARN && st.loss != ELL_WARN;
    events[`ELL_IRQ_FAULT]  = next_st.loss == ELL_FAULT && st.loss != ELL_FAULT;
    events[`ELL_IRQ_REFUSE] = open_refused;
    next_st.int_stat = (st.int_stat & ~clr) | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.port1_loss_action       <= `ELL_RST_PORT1_ACT;
      st.port2_loss_action       <= `ELL_RST_PORT2_ACT;
      st.comm_error_stop_mode    <= `ELL_RST_STOP_MODE;
      st.protocol_slot_select[0] <= `ELL_RST_SLOT0;
      st.protocol_slot_select[1] <= `ELL_RST_SLOT1;
      st.protocol_slot_select[2] <= `ELL_RST_SLOT2;
      st.protocol_slot_select[3] <= `ELL_RST_SLOT3;
      st.loss                    <= ELL_OK;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs
  assign pready            = 1'b1;
  assign prdata            = st.rdata;
  assign pslverr           = psel && penable && st.err;
  assign link_loss_warning = st.loss == ELL_WARN;
  assign link_loss_fault   = st.loss == ELL_FAULT;
  assign alarm_output      = st.alarm;
  assign irq               = |(st.int_stat & st.int_en);

endmodule : ell_link_loss
`default_nettype wire

//--- test/ell_link_loss_checker.sv
// concurrent checks on the link loss policy block ports
// assumes binding onto ell_link_loss, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ell_link_loss_checker
(
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link and drive state
  input wire logic       link_up_p1,
  input wire logic       link_up_p2,
  input wire logic       drive_stopped,
  input wire logic       drive_reset,
  input wire logic       cyclic_active,
  // clients
  input wire logic [3:0] open_req,
  input wire logic [3:0] open_accept,
  // indications
  input wire logic       link_loss_warning,
  input wire logic       link_loss_fault,
  input wire logic       alarm_output
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // sequences
  sequence s_cyc_loss;
    cyclic_active && (!link_up_p1 || !link_up_p2) && !drive_stopped && !drive_reset;
  endsequence
  sequence s_links_up;
    link_up_p1 && link_up_p2;
  endsequence
  // ==========================================================
  // assertions
  a_cyclic_trip: assert property (s_cyc_loss |=> link_loss_fault)
    else $error("no fault on cyclic loss");
  a_fault_cause: assert property ($rose(link_loss_fault) |-> !$past(link_up_p1) || !$past(link_up_p2))
    else $error("fault without loss");
  a_warn_cause: assert property ($rose(link_loss_warning) |-> !$past(link_up_p1) || !$past(link_up_p2))
    else $error("warning without loss");
  a_stop_no_fault: assert property ($rose(link_loss_fault) |-> !$past(drive_stopped) && !$past(drive_reset))
    else $error("fault while stopped or resetting");
  a_reset_clears: assert property (drive_reset |=> !link_loss_fault)
    else $error("fault kept during drive reset");
  a_fault_latch: assert property (link_loss_fault && !drive_reset |=> link_loss_fault)
    else $error("fault dropped without reset");
  a_link_back_quiet: assert property (s_links_up |=> !link_loss_warning && (!alarm_output || link_loss_fault))
    else $error("warning or alarm after link return");
  a_accept_req: assert property ((open_accept & ~open_req) == 4'h0)
    else $error("accept without request");
  a_reset_closed: assert property (drive_reset |-> open_accept == 4'h0)
    else $error("client admitted during drive reset");
endmodule : ell_link_loss_checker
`default_nettype wire

//--- test/ell_link_partner.sv
// link partner model: drops a port link on command, relinks slowly
// assumes commands synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module ell_link_partner
#(
  parameter int RELINK = 4
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // cable commands
  input  wire logic cut_p1,
  input  wire logic cut_p2,
  // link state
  output logic      link_up_p1,
  output logic      link_up_p2
);
  logic [1:0]      up;
  logic [1:0][3:0] cnt;
  assign link_up_p1 = up[0];
  assign link_up_p2 = up[1];
  // relink takes training time, never instant
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up  <= 2'b11;
      cnt <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == 0) ? cut_p1 : cut_p2)
        begin
          up[i]  <= 1'b0;
          cnt[i] <= 4'h0;
        end
        else if (!up[i])
        begin
          cnt[i] <= cnt[i] + 4'h1;
          up[i]  <= (cnt[i] == 4'(RELINK - 1));
        end
      end
    end
  end
endmodule : ell_link_partner
`default_nettype wire

//--- test/ell_link_loss_tb.sv
// self-checking bench of the link loss policy block
// assumes apb with no wait states and the partner model for links
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"
module ell_link_loss_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rdat;
  logic        pready, pslverr, rerr, cut_p1 = 0, cut_p2 = 0, link_up_p1, link_up_p2;
  logic        drive_stopped = 0, drive_reset = 0, cyclic_active = 0;
  logic [3:0]  open_req = '0, close_req = '0, open_accept, acc;
  logic [31:0] prdata;
  logic        link_loss_warning, link_loss_fault, alarm_output, irq;
  int          errors = 0, comparisons = 0, cycles = 0;
  always #25 pclk = ~pclk;
  ell_link_partner #(.RELINK(4)) partner (.pclk(pclk), .presetn(presetn), .cut_p1(cut_p1), .cut_p2(cut_p2),
    .link_up_p1(link_up_p1), .link_up_p2(link_up_p2));
  ell_link_loss uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link_up_p1(link_up_p1), .link_up_p2(link_up_p2), .drive_stopped(drive_stopped),
    .drive_reset(drive_reset), .cyclic_active(cyclic_active), .open_req(open_req), .close_req(close_req),
    .open_accept(open_accept), .link_loss_warning(link_loss_warning), .link_loss_fault(link_loss_fault),
    .alarm_output(alarm_output), .irq(irq));
  task test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================================
  // apb master, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task dreset;
    @(posedge pclk);
    drive_reset <= 1;
    repeat (2) @(posedge pclk);
    drive_reset <= 0;
  endtask : dreset
  task cut(input logic a, input logic b);
    @(posedge pclk);
    cut_p1 <= a;
    cut_p2 <= b;
    settle(10);
  endtask : cut
  task opn(input logic [3:0] o, input logic [3:0] c);
    @(posedge pclk);
    open_req <= o;
    close_req <= c;
    @(negedge pclk);
    acc = open_accept;
    @(posedge pclk);
    open_req <= '0;
    close_req <= '0;
  endtask : opn
  // ==========================================================
  // scenarios
  task t_reset_values;
    logic [11:0] ad [7] = '{`ELL_ADDR_PORT1_ACT, `ELL_ADDR_PORT2_ACT, `ELL_ADDR_STOP_MODE, `ELL_ADDR_SLOT0,
      `ELL_ADDR_SLOT1, `ELL_ADDR_SLOT2, `ELL_ADDR_SLOT3};
    logic [31:0] ex [7] = '{32'h0000_0003, 32'h0000_270F, 32'h0000_0000, 32'h0000_1389, 32'h0000_B0B5,
      32'h0000_B0B6, 32'h0000_270F};
    for (int i = 0; i < 7; i++)
    begin
      apb(0, ad[i], '0);
      chk(rdat, ex[i]);
    end
    apb(0, 12'h040, '0);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
  endtask : t_reset_values
  task t_default_fault;
    apb(1, `ELL_ADDR_INT_EN, 32'h0000_0002);
    cut(1, 0);
    chk({link_loss_fault, alarm_output, irq}, 3'b111);
    apb(1, `ELL_ADDR_INT_CLR, 32'h0000_0002);
    apb(0, `ELL_ADDR_INT_STAT, '0);
    chk({rdat[1], irq}, 2'b00);
    cut(0, 0);
    chk(link_loss_fault, 1);
    dreset();
    settle(1);
    chk({link_loss_fault, alarm_output}, 2'b00);
    @(posedge pclk);
    drive_stopped <= 1;
    cut(0, 1);
    chk({link_loss_fault, link_loss_warning}, 2'b01);
    cut(0, 0);
    @(posedge pclk);
    drive_stopped <= 0;
  endtask : t_default_fault
  task t_actions;
    apb(1, `ELL_ADDR_PORT2_ACT, 32'h0000_0000);
    for (int a = 0; a < 3; a++)
    begin
      apb(1, `ELL_ADDR_PORT1_ACT, 32'(a));
      cut(1, 0);
      chk({link_loss_fault, link_loss_warning, alarm_output}, {1'b0, a != 0, a == 2});
      cut(0, 0);
      chk({link_loss_warning, alarm_output}, 2'b00);
    end
    cut(0, 1);
    chk({link_loss_warning, alarm_output}, 2'b00);
    cut(0, 0);
  endtask : t_actions
  task t_both;
    apb(1, `ELL_ADDR_PORT1_ACT, 32'h0000_0001);
    apb(1, `ELL_ADDR_PORT2_ACT, 32'h0000_22B8);
    cut(1, 0);
    chk(link_loss_warning, 0);
    cut(1, 1);
    chk(link_loss_warning, 1);
    cut(0, 0);
  endtask : t_both
  task t_cyclic;
    apb(1, `ELL_ADDR_PORT1_ACT, 32'h0000_0000);
    apb(1, `ELL_ADDR_PORT2_ACT, 32'h0000_0000);
    apb(1, `ELL_ADDR_STOP_MODE, 32'h0000_0001);
    cyclic_active <= 1;
    cut(0, 1);
    chk(link_loss_fault, 1);
    chk(alarm_output, 0);
    @(posedge pclk);
    cyclic_active <= 0;
    cut(0, 0);
    dreset();
    apb(1, `ELL_ADDR_STOP_MODE, 32'h0000_0000);
  endtask : t_cyclic
  task t_clients;
    logic [3:0] got;
    apb(1, `ELL_ADDR_SLOT1, 32'h0000_01F6);
    apb(1, `ELL_ADDR_SLOT2, 32'h0000_138E);
    apb(0, `ELL_ADDR_SLOT_EFF, '0);
    chk(rdat[2:0], 3'b011);
    for (int i = 0; i < 4; i++)
    begin
      opn(4'h2, 4'h0);
      got[i] = acc[1];
    end
    chk(got, 4'b0111);
    apb(0, `ELL_ADDR_INT_STAT, '0);
    chk(rdat[2], 1);
    opn(4'h0, 4'h2);
    opn(4'h2, 4'h0);
    chk(acc[1], 1);
    dreset();
    for (int i = 0; i < 3; i++)
    begin
      opn(4'h2, 4'h0);
      got[i] = acc[1];
    end
    chk(got[2:0], 3'b111);
  endtask : t_clients
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset_values();
    t_default_fault();
    t_actions();
    t_both();
    t_cyclic();
    t_clients();
    test_done();
  end
endmodule : ell_link_loss_tb
bind ell_link_loss ell_link_loss_checker chk_i (.pclk(pclk), .presetn(presetn), .link_up_p1(link_up_p1),
  .link_up_p2(link_up_p2), .drive_stopped(drive_stopped), .drive_reset(drive_reset),
  .cyclic_active(cyclic_active), .open_req(open_req), .open_accept(open_accept),
  .link_loss_warning(link_loss_warning), .link_loss_fault(link_loss_fault), .alarm_output(alarm_output));
`default_nettype wire
